/* File: pwc_channel.sv */
// one pwm channel: counter, left-aligned output and register slave
`timescale 1ns/10ps
// What this block does
// - counter reads are free and never disturb count or operation
// - any counter write with byte lane 0 enabled clears count, sets up, loads buffers, output from polarity
// - with enable bit low the counter holds its value
// - on re-enable the counter resumes from the value it holds
// - disabled and period written zero: counter clears on next selected tick
// - counter write while enabled restarts the period at once
// - alignment-select bit clear picks left-aligned output
// - left-aligned mode counts upward only, eight bits wide
// - count equal to active duty toggles the output flip-flop
// - count reaching active period resets counter, output, loads buffers
// - count runs zero to period minus one, then starts again
module pwc_channel #(
  parameter int CNT_W = pwc_pkg::CNT_W
) (
  // clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_b_i,
  // avalon-mm slave
  input  wire logic [pwc_pkg::ADDR_W-1:0] avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [pwc_pkg::DATA_W-1:0] avs_writedata_i,
  input  wire logic [3:0]                 avs_byteenable_i,
  output logic      [pwc_pkg::DATA_W-1:0] avs_readdata_o,
  output logic                            avs_waitrequest_o,
  // waveform
  output logic                            pwm_o
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_q1;
  logic rst_n;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [2:0]       ctrl;
  logic [CNT_W-1:0] per_buf;
  logic [CNT_W-1:0] duty_buf;
  logic [CNT_W-1:0] presc;
  logic             wait_q;
  logic [31:0]      rdata_q;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] per_act;
  logic [CNT_W-1:0] duty_act;
  logic             out_q;
  logic             dir_up;
  logic             clr_pend;

  logic [2:0]       next_ctrl;
  logic [CNT_W-1:0] next_per_buf;
  logic [CNT_W-1:0] next_duty_buf;
  logic [CNT_W-1:0] next_presc;
  logic             next_wait_q;
  logic [31:0]      next_rdata_q;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] next_per_act;
  logic [CNT_W-1:0] next_duty_act;
  logic             next_out_q;
  logic             next_dir_up;
  logic             next_clr_pend;

  logic             req;
  logic             wr_take;
  logic             rd_take;
  logic             cnt_wr;
  logic             per_zero_wr;
  logic             enable;
  logic             align_center;
  logic             polarity;
  logic             run;
  logic             wrap;
  logic [CNT_W:0]   cnt_inc;

  // ----------------------------------------
  // selected clock divider
  // ----------------------------------------
  pwc_tick_if tk ();

  assign tk.limit = presc;

  pwc_tick_div #(
    .DIV_W (CNT_W)
  ) u_div (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_n),
    .tk        (tk.src)
  );

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  assign req          = avs_read_i | avs_write_i;
  assign wr_take      = avs_write_i & ~wait_q & avs_byteenable_i[0];
  assign rd_take      = avs_read_i & wait_q;
  assign cnt_wr       = wr_take & (avs_address_i[4:2] == pwc_pkg::OFF_COUNT[4:2]);
  assign per_zero_wr  = wr_take & (avs_address_i[4:2] == pwc_pkg::OFF_PERIOD[4:2])
                        & (avs_writedata_i[CNT_W-1:0] == '0);
  assign enable       = ctrl[pwc_pkg::CTRL_EN_BIT];
  assign align_center = ctrl[pwc_pkg::CTRL_ALIGN_BIT];
  assign polarity     = ctrl[pwc_pkg::CTRL_POL_BIT];

  // ----------------------------------------
  // registers and bus answer
  // ----------------------------------------
  always_comb begin
    next_ctrl     = ctrl;
    next_per_buf  = per_buf;
    next_duty_buf = duty_buf;
    next_presc    = presc;
    next_wait_q   = ~(req & wait_q);
    next_rdata_q  = rdata_q;
    if (wr_take) begin
      case (avs_address_i[4:2])
        pwc_pkg::OFF_CTRL[4:2]:   next_ctrl     = avs_writedata_i[2:0];
        pwc_pkg::OFF_PERIOD[4:2]: next_per_buf  = avs_writedata_i[CNT_W-1:0];
        pwc_pkg::OFF_DUTY[4:2]:   next_duty_buf = avs_writedata_i[CNT_W-1:0];
        pwc_pkg::OFF_PRESC[4:2]:  next_presc    = avs_writedata_i[CNT_W-1:0];
        default:                  next_ctrl     = ctrl;
      endcase
    end
    if (rd_take) begin
      next_rdata_q = '0;
      case (avs_address_i[4:2])
        pwc_pkg::OFF_CTRL[4:2]:    next_rdata_q[2:0]       = ctrl;
        pwc_pkg::OFF_PERIOD[4:2]:  next_rdata_q[CNT_W-1:0] = per_buf;
        pwc_pkg::OFF_DUTY[4:2]:    next_rdata_q[CNT_W-1:0] = duty_buf;
        pwc_pkg::OFF_COUNT[4:2]:   next_rdata_q[CNT_W-1:0] = cnt;
        pwc_pkg::OFF_STATUS[4:2]: begin
          next_rdata_q[pwc_pkg::STAT_OUT_BIT]  = out_q;
          next_rdata_q[pwc_pkg::STAT_UP_BIT]   = dir_up;
          next_rdata_q[pwc_pkg::STAT_PEND_BIT] = clr_pend;
        end
        pwc_pkg::OFF_ACT_PER[4:2]: next_rdata_q[CNT_W-1:0] = per_act;
        pwc_pkg::OFF_ACT_DTY[4:2]: next_rdata_q[CNT_W-1:0] = duty_act;
        pwc_pkg::OFF_PRESC[4:2]:   next_rdata_q[CNT_W-1:0] = presc;
        default:                   next_rdata_q            = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl     <= pwc_pkg::CTRL_RST;
      per_buf  <= pwc_pkg::PER_RST;
      duty_buf <= pwc_pkg::DUTY_RST;
      presc    <= pwc_pkg::PRESC_RST;
      wait_q   <= 1'b1;
      rdata_q  <= '0;
    end else begin
      ctrl     <= next_ctrl;
      per_buf  <= next_per_buf;
      duty_buf <= next_duty_buf;
      presc    <= next_presc;
      wait_q   <= next_wait_q;
      rdata_q  <= next_rdata_q;
    end
  end

  // ----------------------------------------
  // channel counter and output flip-flop
  // ----------------------------------------
  assign run     = tk.tick & enable & ~align_center & ~clr_pend;
  assign cnt_inc = {1'b0, cnt} + {{CNT_W{1'b0}}, 1'b1};
  assign wrap    = run & ((cnt_inc == {1'b0, per_act}) | (per_act == '0));

  always_comb begin
    next_cnt      = cnt;
    next_per_act  = per_act;
    next_duty_act = duty_act;
    next_out_q    = out_q;
    next_dir_up   = dir_up;
    next_clr_pend = clr_pend;
    if (per_zero_wr & ~enable) begin
      next_clr_pend = 1'b1;
    end
    if (cnt_wr) begin
      next_cnt      = '0;
      next_dir_up   = 1'b1;
      next_per_act  = per_buf;
      next_duty_act = duty_buf;
      next_out_q    = polarity;
      next_clr_pend = 1'b0;
    end else if (tk.tick & clr_pend) begin
      next_cnt      = '0;
      next_clr_pend = per_zero_wr & ~enable;
    end else if (wrap) begin
      next_cnt      = '0;
      next_per_act  = per_buf;
      next_duty_act = duty_buf;
      next_out_q    = polarity;
    end else if (run) begin
      next_cnt = cnt_inc[CNT_W-1:0];
      if (cnt_inc[CNT_W-1:0] == duty_act) begin
        next_out_q = ~out_q;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt      <= '0;
      per_act  <= pwc_pkg::PER_RST;
      duty_act <= pwc_pkg::DUTY_RST;
      out_q    <= 1'b0;
      dir_up   <= 1'b1;
      clr_pend <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      per_act  <= next_per_act;
      duty_act <= next_duty_act;
      out_q    <= next_out_q;
      dir_up   <= next_dir_up;
      clr_pend <= next_clr_pend;
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign pwm_o             = out_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_read_quiet:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (rd_take && !tk.tick && !cnt_wr) |=> (cnt == $past(cnt)) && (rdata_q[CNT_W-1:0]
        == $past(cnt) || $past(avs_address_i[4:2]) != pwc_pkg::OFF_COUNT[4:2]))
    else $error("counter read disturbed the count");

  chk_write_clears:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      cnt_wr |=> (cnt == '0) && dir_up && (per_act == $past(per_buf))
                 && (duty_act == $past(duty_buf)))
    else $error("counter write did not clear and load");

  chk_disabled_hold:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (!enable && !cnt_wr && !clr_pend) |=> $stable(cnt))
    else $error("disabled counter moved");

  chk_resume_step:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (run && !wrap && !cnt_wr) |=> (cnt == $past(cnt) + 8'h01))
    else $error("enabled counter did not step by one");

  chk_zero_period:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (per_zero_wr && !enable && !cnt_wr) |=> clr_pend)
    else $error("zero period write did not arm the counter clear");

  chk_pend_clear:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (clr_pend && tk.tick && !cnt_wr) |=> (cnt == '0))
    else $error("pending clear did not zero the counter on the tick");

  chk_restart_out:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      cnt_wr |=> (out_q == $past(polarity)))
    else $error("counter write did not set output from polarity");

  chk_center_hold:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (align_center && !cnt_wr && !clr_pend) |=> $stable(cnt))
    else $error("counter ran with left alignment not selected");

  chk_duty_toggle:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (run && !wrap && !cnt_wr && cnt_inc[CNT_W-1:0] == duty_act) |=> (out_q != $past(out_q)))
    else $error("duty match did not toggle output");

  chk_period_wrap:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (wrap && !cnt_wr) |=> (cnt == '0) && (out_q == $past(polarity))
                            && (per_act == $past(per_buf)))
    else $error("period match did not restart the cycle");

  chk_no_tick_hold:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      (!tk.tick && !cnt_wr) |=> $stable(cnt))
    else $error("counter moved between ticks");

endmodule

/* File: pwc_pkg.sv */
// constants shared by the pwm channel block
package pwc_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int CNT_W  = 8;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL    = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_PERIOD  = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_DUTY    = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_COUNT   = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_ACT_PER = 5'h14;
  localparam logic [ADDR_W-1:0] OFF_ACT_DTY = 5'h18;
  localparam logic [ADDR_W-1:0] OFF_PRESC   = 5'h1c;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_ALIGN_BIT = 1;
  localparam int CTRL_POL_BIT   = 2;
  localparam int STAT_OUT_BIT   = 0;
  localparam int STAT_UP_BIT    = 1;
  localparam int STAT_PEND_BIT  = 2;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [2:0]       CTRL_RST  = 3'h0;
  localparam logic [CNT_W-1:0] PER_RST   = 8'hff;
  localparam logic [CNT_W-1:0] DUTY_RST  = 8'h00;
  localparam logic [CNT_W-1:0] PRESC_RST = 8'h00;

endpackage

/* File: pwc_tick_div.sv */
// divider that makes the channel's selected clock as an enable pulse
`timescale 1ns/10ps
module pwc_tick_div #(
  parameter int DIV_W = pwc_pkg::CNT_W
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  // tick link
  pwc_tick_if.src   tk
);

  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic             tick_q;
  logic             next_tick_q;

  // ----------------------------------------
  // divide by limit plus one
  // ----------------------------------------
  always_comb begin
    next_div_cnt = div_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
    next_tick_q  = 1'b0;
    if (div_cnt >= tk.limit) begin
      next_div_cnt = '0;
      next_tick_q  = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_cnt <= '0;
      tick_q  <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tick_q  <= next_tick_q;
    end
  end

  assign tk.tick = tick_q;

endmodule

/* File: pwc_tick_if.sv */
// interface between the channel and its selected-clock divider
`timescale 1ns/10ps
interface pwc_tick_if;
  logic [pwc_pkg::CNT_W-1:0] limit;
  logic                      tick;

  modport src (
    input  limit,
    output tick
  );
  modport user (
    output limit,
    input  tick
  );
endinterface

/* File: pwm_channel_counter_left_aligned_tb.sv */
// self-checking testbench for the pwm channel block
`timescale 1ns/10ps
module pwm_channel_counter_left_aligned_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  typedef struct {logic [31:0] exp; bit chk; string name;} pwc_note_t;
  logic        ref_clk_i;
  logic        rst_b_i;
  logic [4:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        pwm_o;
  pwc_note_t   notes[$];
  pwc_note_t   mon_note;
  int          err_count;
  int          n_checks;
  logic [31:0] c1;
  logic [31:0] c2;
  int          per;
  int          dty;

  pwc_channel dut (
    .ref_clk_i        (ref_clk_i),
    .rst_b_i          (rst_b_i),
    .avs_address_i    (avs_address_i),
    .avs_read_i       (avs_read_i),
    .avs_write_i      (avs_write_i),
    .avs_writedata_i  (avs_writedata_i),
    .avs_byteenable_i (avs_byteenable_i),
    .avs_readdata_o   (avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .pwm_o            (pwm_o)
  );

  initial ref_clk_i = 1'b0;
  always #25 ref_clk_i = ~ref_clk_i;

  // ----------------------------------------
  // compare, verdict and bus tasks
  // ----------------------------------------
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic bus(input logic rw, input logic [4:0] adr, input logic [31:0] wd,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    @(posedge ref_clk_i);
    avs_address_i    <= adr;
    avs_write_i      <= rw;
    avs_read_i       <= ~rw;
    avs_writedata_i  <= wd;
    avs_byteenable_i <= be;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (n >= 20) begin
      chk_val("waitrequest", 32'h0, 32'h1);
      complete_run;
    end
    rd = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] adr, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, adr, wd, 4'hf, d);
  endtask

  task automatic rd(input string what, input logic [4:0] adr, input logic [31:0] exp,
                    input bit chk, output logic [31:0] d);
    notes.push_back('{exp, chk, what});
    bus(1'b0, adr, 32'h0, 4'hf, d);
  endtask

  task automatic expect_rd(input string what, input logic [4:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    rd(what, adr, exp, 1'b1, d);
  endtask

  // ----------------------------------------
  // read answer monitor
  // ----------------------------------------
  always @(posedge ref_clk_i) begin
    if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
      if (notes.size() == 0) begin
        chk_val("note queue", 32'h1, 32'h0);
      end else begin
        mon_note = notes.pop_front();
        if (mon_note.chk) begin
          chk_val(mon_note.name, mon_note.exp, avs_readdata_o);
        end
      end
    end
  end

  // ----------------------------------------
  // waveform measurement over four periods
  // ----------------------------------------
  task automatic wave(input int p, input int d, input int pre, input logic pol);
    int   highs;
    int   rises;
    logic prev;
    wr(pwc_pkg::OFF_CTRL, {29'h0, pol, 2'h0});
    wr(pwc_pkg::OFF_PERIOD, 32'(p));
    wr(pwc_pkg::OFF_DUTY, 32'(d));
    wr(pwc_pkg::OFF_PRESC, 32'(pre));
    wr(pwc_pkg::OFF_COUNT, $urandom);
    expect_rd("active period", pwc_pkg::OFF_ACT_PER, 32'(p));
    expect_rd("active duty", pwc_pkg::OFF_ACT_DTY, 32'(d));
    expect_rd("status", pwc_pkg::OFF_STATUS, {30'h0, 1'b1, pol});
    wr(pwc_pkg::OFF_CTRL, {29'h0, pol, 2'h1});
    repeat (2 * p * (pre + 1)) @(posedge ref_clk_i);
    prev  = pwm_o;
    highs = 0;
    rises = 0;
    repeat (4 * p * (pre + 1)) begin
      @(posedge ref_clk_i);
      if (pwm_o === 1'b1) highs++;
      if (pwm_o === 1'b1 && prev === 1'b0) rises++;
      prev = pwm_o;
    end
    chk_val("high cycles", 32'(4 * (pol ? d : p - d) * (pre + 1)), 32'(highs));
    chk_val("rising edges", 32'h4, 32'(rises));
  endtask

  // ----------------------------------------
  // timeout
  // ----------------------------------------
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    chk_val("run time", 32'h0, 32'h1);
    complete_run;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_b_i          = 1'b0;
    avs_address_i    = 5'h00;
    avs_read_i       = 1'b0;
    avs_write_i      = 1'b0;
    avs_writedata_i  = 32'h0;
    avs_byteenable_i = 4'h0;
    err_count        = 0;
    n_checks         = 0;
    void'($urandom(32'ha9aa0d59));
    repeat (2) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    expect_rd("ctrl", pwc_pkg::OFF_CTRL, 32'(pwc_pkg::CTRL_RST));
    expect_rd("period", pwc_pkg::OFF_PERIOD, 32'(pwc_pkg::PER_RST));
    expect_rd("duty", pwc_pkg::OFF_DUTY, 32'(pwc_pkg::DUTY_RST));
    expect_rd("count", pwc_pkg::OFF_COUNT, 32'h0);
    expect_rd("status", pwc_pkg::OFF_STATUS, 32'h2);
    expect_rd("active period", pwc_pkg::OFF_ACT_PER, 32'(pwc_pkg::PER_RST));
    expect_rd("presc", pwc_pkg::OFF_PRESC, 32'(pwc_pkg::PRESC_RST));
    $display("test reset values done");
    for (int k = 0; k < 4; k++) begin
      per = 2 + $urandom % 9;
      dty = 1 + $urandom % (per - 1);
      wave(per, dty, $urandom % 3, k[0]);
    end
    $display("test left aligned waveforms done");
    wr(pwc_pkg::OFF_CTRL, 32'h0);
    wr(pwc_pkg::OFF_PRESC, 32'h0);
    wr(pwc_pkg::OFF_PERIOD, 32'd200);
    wr(pwc_pkg::OFF_COUNT, 32'h5a);
    repeat (20) @(posedge ref_clk_i);
    expect_rd("held count", pwc_pkg::OFF_COUNT, 32'h0);
    wr(pwc_pkg::OFF_CTRL, 32'h3);
    repeat (20) @(posedge ref_clk_i);
    expect_rd("count in center mode", pwc_pkg::OFF_COUNT, 32'h0);
    wr(pwc_pkg::OFF_CTRL, 32'h1);
    repeat (30) @(posedge ref_clk_i);
    wr(pwc_pkg::OFF_CTRL, 32'h0);
    rd("count", pwc_pkg::OFF_COUNT, 32'h0, 1'b0, c1);
    chk_val("count advance", 32'h1, 32'(c1 >= 30 && c1 <= 40));
    repeat (20) @(posedge ref_clk_i);
    wr(pwc_pkg::OFF_CTRL, 32'h1);
    repeat (10) @(posedge ref_clk_i);
    wr(pwc_pkg::OFF_CTRL, 32'h0);
    rd("count", pwc_pkg::OFF_COUNT, 32'h0, 1'b0, c2);
    chk_val("count resumed", 32'h1, 32'(c2 >= c1 + 10 && c2 <= c1 + 16));
    $display("test hold and resume done");
    wr(pwc_pkg::OFF_PERIOD, 32'h0);
    repeat (3) @(posedge ref_clk_i);
    expect_rd("count after zero period", pwc_pkg::OFF_COUNT, 32'h0);
    $display("test zero period clear done");
    wr(pwc_pkg::OFF_PERIOD, 32'd200);
    wr(pwc_pkg::OFF_DUTY, 32'd50);
    wr(pwc_pkg::OFF_CTRL, 32'h4);
    wr(pwc_pkg::OFF_COUNT, 32'h0);
    wr(pwc_pkg::OFF_CTRL, 32'h5);
    repeat (120) @(posedge ref_clk_i);
    expect_rd("status past duty", pwc_pkg::OFF_STATUS, 32'h2);
    wr(pwc_pkg::OFF_PERIOD, 32'd150);
    wr(pwc_pkg::OFF_COUNT, $urandom);
    expect_rd("status after restart", pwc_pkg::OFF_STATUS, 32'h3);
    expect_rd("active period", pwc_pkg::OFF_ACT_PER, 32'd150);
    rd("count", pwc_pkg::OFF_COUNT, 32'h0, 1'b0, c1);
    chk_val("count after restart", 32'h1, 32'(c1 <= 10));
    bus(1'b1, pwc_pkg::OFF_PERIOD, 32'h33, 4'h0, c2);
    expect_rd("period kept", pwc_pkg::OFF_PERIOD, 32'd150);
    $display("test restart while enabled done");
    complete_run;
  end
endmodule
